// ===== design/crt_pkg.sv
// package: register map, field layout and timing constants of the core ripple timer
package crt_pkg;
  // register byte offsets (printed offsets are not all multiples of four: index * 4)
  localparam logic [7:0]  CRT_IDX_STATUS_CONTROL = 8'h08;
  localparam logic [7:0]  CRT_IDX_COUNTER_VALUE  = 8'h09;
  localparam logic [11:0] CRT_ADDR_STATUS_CONTROL = 12'h020;
  localparam logic [11:0] CRT_ADDR_COUNTER_VALUE  = 12'h024;
  localparam logic [11:0] CRT_ADDR_WDOG_FEED      = 12'h028;
  localparam logic [15:0] CRT_WDOG_FEED_CPU_ADDR  = 16'h3ff0;
  // status/control field positions
  localparam int CRT_BIT_WRAP_FLAG     = 7;
  localparam int CRT_BIT_PER_FLAG      = 6;
  localparam int CRT_BIT_WRAP_IRQ_EN   = 5;
  localparam int CRT_BIT_PER_IRQ_EN    = 4;
  localparam int CRT_BIT_WRAP_CLR      = 3;
  localparam int CRT_BIT_PER_CLR       = 2;
  localparam int CRT_BIT_RATE_LO       = 0;
  localparam logic [1:0] CRT_RATE_RESET = 2'h3;
  // chain geometry: prescale 2 + counter 8 + 2 stages + 3 periodic stages = 15 bits
  localparam int CRT_CHAIN_W   = 15;
  localparam int CRT_PRESC_W   = 2;
  localparam int CRT_WRAP_BIT  = 9;
  localparam int CRT_PER_BASE  = 10;
  localparam int CRT_WDOG_W    = 3;
  // watchdog reset pulse length
  localparam int CRT_WDOG_RST_CYC = 3;
  // axi response codes
  localparam logic [1:0] CRT_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CRT_RESP_SLVERR = 2'h2;
endpackage

// ===== design/crt_wdog.sv
// watchdog divide-by-eight stage and reset pulse stretcher
`timescale 1ns/1ps
module crt_wdog
  import crt_pkg::*;
#(
  parameter int PULSE_CYC = CRT_WDOG_RST_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  input  wire logic tick,
  input  wire logic feed,
  output logic      timeout
);
  typedef struct packed {
    logic [CRT_WDOG_W-1:0] div;
    logic [2:0]            hold;
    logic                  out;
  } crt_wd_s;
  crt_wd_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    if (feed) begin
      st_d.div = '0;  // [R16]
    end else if (tick) begin
      st_d.div = st_q.div + 1'b1;  // [R5]
      if (&st_q.div && enable) begin
        st_d.hold = 3'(PULSE_CYC);  // [R17] [R20]
      end
    end
    if (st_q.hold != 3'h0 && !(tick && &st_q.div && enable && !feed)) begin
      st_d.hold = st_q.hold - 1'b1;
    end
    st_d.out = (st_d.hold != 3'h0);  // [R17]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign timeout = st_q.out;
endmodule

// ===== design/crt_core_timer.sv
// core ripple timer with periodic interrupt, axi4-lite slave and watchdog
`timescale 1ns/1ps
// Operation
// R1 - fifteen-bit synchronous chain: bus clock over four drives an 8-bit counter
// R2 - counter register at index 09 reads the live count without disturbing it
// R3 - wrap event taken at the counter's last stage, once every 1024 cycles
// R4 - two more stages give clock over 2048, feeding three periodic stages
// R5 - selected periodic tap divided by eight clocks the watchdog
// R6 - rate, enables, flags and clear bits share the register at index 08
// R7 - wrap flag sets on FF to 00, ignores writes, cleared by reset
// R8 - periodic flag sets on selected tap going active, ignores writes
// R9 - interrupt request when wrap enable and wrap flag both set
// R10 - interrupt request when periodic enable and periodic flag both set
// R11 - writing one to wrap clear bit clears wrap flag; reads zero
// R12 - writing one to periodic clear bit clears periodic flag; reads zero
// R13 - rate 00,01,10,11 give periods of 2^11,2^12,2^13,2^14 cycles
// R14 - reset sets both rate bits, the slowest rate
// R15 - software should feed the watchdog before changing the rate select
// R16 - feed clears only the final divide-by-eight stage
// R17 - timeout gives internal reset and drives reset pin low three cycles
// R18 - any chip reset clears the whole divider chain
// R19 - chain, interrupts and watchdog keep running while the cpu waits
// R20 - watchdog enable is a static input; when low no timeout ever
// R21 - each flag sets for one edge per period; set wins over clear
module crt_core_timer
  import crt_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        wdog_enable,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             cpu_irq,
  output logic             wdog_reset_n
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [CRT_CHAIN_W-1:0] chain;
    logic [1:0]             rate;
    logic                   wrap_flag;
    logic                   per_flag;
    logic                   wrap_en;
    logic                   per_en;
    logic                   aw_got;
    logic [11:0]            aw_addr;
    logic                   w_got;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   irq;
  } crt_s;
  crt_s st_q, st_d;

  logic wd_timeout;
  logic wd_tick;
  logic wd_feed;

  // ****************************************
  // helpers
  // ****************************************
  // carry into bit b on the next edge: all lower bits are ones, once every 2^b cycles
  function automatic logic rises(input logic [CRT_CHAIN_W-1:0] c, input int b);
    logic [CRT_CHAIN_W-1:0] m;
    m = (CRT_CHAIN_W'(1) << b) - CRT_CHAIN_W'(1);
    return ((c & m) == m);
  endfunction

  function automatic logic [7:0] status_byte(input crt_s s);
    logic [7:0] v;
    v = 8'h00;
    v[CRT_BIT_WRAP_FLAG]   = s.wrap_flag;
    v[CRT_BIT_PER_FLAG]    = s.per_flag;
    v[CRT_BIT_WRAP_IRQ_EN] = s.wrap_en;
    v[CRT_BIT_PER_IRQ_EN]  = s.per_en;
    v[CRT_BIT_RATE_LO +: 2] = s.rate;  // clear bits stay zero [R11] [R12]
    return v;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  logic       wrap_ev;
  logic       per_ev;
  logic       do_write;
  logic       wr_ctrl;
  logic [7:0] wb;
  int         tap;

  always_comb begin
    st_d     = st_q;
    tap      = CRT_PER_BASE + 1 + int'(st_q.rate);  // [R13]
    // free-running chain, never gated by cpu wait state [R1] [R19]
    st_d.chain = st_q.chain + 1'b1;
    // counter rolls FF->00 on the carry out of bit 9 [R3] [R7]
    wrap_ev  = rises(st_q.chain, CRT_WRAP_BIT + 1);
    // selected periodic tap goes active; tap change may drop/add one event [R8] [R15]
    per_ev   = rises(st_q.chain, tap);
    wd_tick  = per_ev;  // [R5]

    // axi write address / data capture, either order
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
      st_d.awready = 1'b0;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_got  = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
      st_d.wready = 1'b0;
    end
    do_write = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    wb       = st_q.w_data[7:0];
    wr_ctrl  = do_write && st_q.w_strb[0] && st_q.aw_addr[11:2] == CRT_ADDR_STATUS_CONTROL[11:2];
    wd_feed  = do_write && st_q.w_strb[0] && st_q.aw_addr[11:2] == CRT_ADDR_WDOG_FEED[11:2]
               && !wb[0];  // [R16]
    if (do_write) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = (st_q.aw_addr[11:2] == CRT_ADDR_STATUS_CONTROL[11:2] ||
                     st_q.aw_addr[11:2] == CRT_ADDR_COUNTER_VALUE[11:2] ||
                     st_q.aw_addr[11:2] == CRT_ADDR_WDOG_FEED[11:2]) ?
                    CRT_RESP_OKAY : CRT_RESP_SLVERR;
    end
    if (wr_ctrl) begin  // [R6]
      st_d.wrap_en = wb[CRT_BIT_WRAP_IRQ_EN];
      st_d.per_en  = wb[CRT_BIT_PER_IRQ_EN];
      st_d.rate    = wb[CRT_BIT_RATE_LO +: 2];
      if (wb[CRT_BIT_WRAP_CLR]) begin
        st_d.wrap_flag = 1'b0;  // [R11]
      end
      if (wb[CRT_BIT_PER_CLR]) begin
        st_d.per_flag = 1'b0;  // [R12]
      end
    end
    // flag positions ignore writes; set overrides same-cycle clear [R7] [R8] [R21]
    if (wrap_ev) begin
      st_d.wrap_flag = 1'b1;
    end
    if (per_ev) begin
      st_d.per_flag = 1'b1;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid  = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready  = 1'b1;
    end

    // axi read: one outstanding read
    if (s_axi_arvalid && st_q.arready) begin
      st_d.arready = 1'b0;
      st_d.rvalid  = 1'b1;
      st_d.rresp   = CRT_RESP_OKAY;
      unique case (s_axi_araddr[11:2])
        CRT_ADDR_STATUS_CONTROL[11:2]: st_d.rdata = {24'h00_0000, status_byte(st_q)};
        // live count, reading has no side effect [R2]
        CRT_ADDR_COUNTER_VALUE[11:2]:  st_d.rdata = {24'h00_0000,
                                                     st_q.chain[CRT_PRESC_W +: 8]};
        CRT_ADDR_WDOG_FEED[11:2]:      st_d.rdata = 32'h0000_0000;
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = CRT_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end

    st_d.irq = (st_d.wrap_en && st_d.wrap_flag) ||  // [R9]
               (st_d.per_en && st_d.per_flag);      // [R10]
  end

  // ****************************************
  // registers
  // ****************************************
  // watchdog timeout acts as a chip reset too, clearing the chain [R17] [R18]
  always_ff @(posedge aclk) begin
    if (!aresetn || wd_timeout) begin
      st_q         <= '0;  // [R18]
      st_q.rate    <= CRT_RATE_RESET;  // [R14]
      st_q.awready <= 1'b1;
      st_q.wready  <= 1'b1;
      st_q.arready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  crt_wdog #(
    .PULSE_CYC(CRT_WDOG_RST_CYC)
  ) u_wdog (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (wdog_enable),
    .tick    (wd_tick),
    .feed    (wd_feed),
    .timeout (wd_timeout)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign cpu_irq       = st_q.irq;
  assign wdog_reset_n  = !wd_timeout;  // [R17]
endmodule

// ===== test/crt_core_timer_properties.sv
// checker: port-level properties of the core ripple timer
`timescale 1ns/1ps
module crt_props
  import crt_pkg::*;
(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic [11:0] s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        cpu_irq,
  input logic        wdog_reset_n
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_idle_a: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !cpu_irq && wdog_reset_n)
    else $error("outputs not idle after reset");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  count_read_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == CRT_ADDR_COUNTER_VALUE
    |=> s_axi_rresp == CRT_RESP_OKAY && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("counter read malformed");
  unmapped_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > CRT_ADDR_WDOG_FEED
    |=> s_axi_rresp == CRT_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // the pin must be low long enough for an external reset to be seen
  wdog_pulse_a: assert property (
    $fell(wdog_reset_n) |-> !wdog_reset_n [*3] ##1 wdog_reset_n)
    else $error("watchdog reset pulse length wrong");
endmodule
bind crt_core_timer crt_props crt_props_i (.*);

// ===== test/crt_core_timer_tb.sv
// testbench: registers, flags, rates and watchdog of the core ripple timer
`timescale 1ns/1ps
module crt_core_timer_tb;
  import crt_pkg::*;
  logic        aclk = 0, aresetn = 0, wdog_enable = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, cpu_irq, wdog_reset_n;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          failures = 0, checks = 0, cyc = 0;
  localparam logic [11:0] SC = CRT_ADDR_STATUS_CONTROL;

  crt_core_timer crt_core_timer_i (.*);
  always #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;
  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic wait_irq;
    do @(posedge aclk); while (cpu_irq !== 1'b1);
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(SC); check("status reset", v, 32'h0000_0003);
    rd(12'h03c); check("unmapped", {30'h0, r}, {30'h0, CRT_RESP_SLVERR});
    wr(12'h03c, 32'h0000_0000); check("unmapped wr", {30'h0, r}, {30'h0, CRT_RESP_SLVERR});
    wr(SC, 32'h0000_0030); check("write okay", {30'h0, r}, {30'h0, CRT_RESP_OKAY});
    rd(SC); check("enables", v, 32'h0000_0030);
    wait_irq; rd(SC); check("wrap flag", v, 32'h0000_00b0);
    wr(SC, 32'h0000_00f0); rd(SC); check("flag write", v, 32'h0000_00b0);
    wr(SC, 32'h0000_0038); rd(SC); check("wrap clear", v, 32'h0000_0030);
    check("irq low", {31'h0, cpu_irq}, 32'h0000_0000);
    rd(CRT_ADDR_COUNTER_VALUE); check("count hi", {v[31:8], 6'h0, r}, 32'h0);
    // wrap and periodic events coincide at 2048 cycles on rate 00, the fastest rate
    wait_irq; rd(SC); check("both flags", v, 32'h0000_00f0);
    wr(SC, 32'h0000_0034); rd(SC); check("per clear", v, 32'h0000_00b0);
    wr(SC, 32'h0000_003c); rd(SC); check("all clear", v, 32'h0000_0030);
    // each rate switch lands while the new tap bit is low, so no stray tick
    for (int k = 1; k < 4; k++) begin
      wr(CRT_ADDR_WDOG_FEED, 32'h0000_0000);
      wr(SC, 32'h0000_0014 | k);
      wait_irq;
      check("rate period", 32'(cyc % (2048 << k) < 8), 32'h1);
    end
    wr(CRT_ADDR_WDOG_FEED, 32'h0000_0000);
    wr(SC, 32'h0000_0004);
    do @(posedge aclk); while (wdog_reset_n !== 1'b0);
    // eight ticks of 2048 after the feed, not after reset
    check("feed delay", 32'(cyc >> 11), 32'd16);
    repeat (4) @(posedge aclk);
    rd(SC); check("timeout reset", v, 32'h0000_0003);
    give_verdict;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    give_verdict;
  end
endmodule
